// File: src/mic_pkg.sv
// ----------------------------------------------------------------------------
// shared constants and types for the memory i/o compensation and dll controls
// ----------------------------------------------------------------------------
package mic_pkg;

	// bus geometry
	localparam int unsigned MIC_ADDR_W = 8;
	localparam int unsigned MIC_DATA_W = 32;
	localparam int unsigned MIC_BE_W = 4;

	// register byte offsets
	localparam logic [7:0] MIC_COMP_OFS = 8'h98;
	localparam logic [7:0] MIC_DLL_OFS = 8'h9C;
	localparam logic [7:0] MIC_RXTAP_OFS = 8'hC0;

	// field positions in the compensation register
	localparam int unsigned MIC_VERT_OVR_BIT = 31;
	localparam int unsigned MIC_VERT_P_LSB = 20;
	localparam int unsigned MIC_VERT_N_LSB = 16;
	localparam int unsigned MIC_HORIZ_OVR_BIT = 15;
	localparam int unsigned MIC_HORIZ_P_LSB = 4;
	localparam int unsigned MIC_HORIZ_N_LSB = 0;
	localparam int unsigned MIC_CODE_W = 3;

	// field positions in the dll and tap registers
	localparam int unsigned MIC_TX_DIS_BIT = 15;
	localparam int unsigned MIC_RX_TAP_LSB = 0;
	localparam int unsigned MIC_TAP_W = 3;
	localparam int unsigned MIC_TAP_COUNT = 8;

	// implemented bits per register, everything else reads as zero
	localparam logic [31:0] MIC_COMP_MASK = 32'h8077_8077;
	localparam logic [31:0] MIC_DLL_MASK = 32'h0000_8000;
	localparam logic [31:0] MIC_RXTAP_MASK = 32'h0000_0007;

	// values after reset
	localparam logic MIC_OVR_RST = 1'b0;
	localparam logic MIC_TX_DIS_RST = 1'b0;
	localparam logic [2:0] MIC_RX_TAP_RST = 3'h0;
	localparam logic [2:0] MIC_CODE_RST = 3'h0;
	localparam logic [31:0] MIC_RDATA_RST = 32'h0000_0000;

	// cycles from a taken request to waitrequest low
	localparam int unsigned MIC_BUS_LATENCY = 1;

	// one pair of drive codes for a buffer orientation
	typedef struct packed {
		logic [2:0] pchan;
		logic [2:0] nchan;
	} mic_code_s;

	// bus slave sequencing
	typedef enum logic [1:0] {
		MIC_BUS_IDLE = 2'b01,
		MIC_BUS_ACK = 2'b10
	} mic_bus_state_e;

	// whole state of the register block
	typedef struct packed {
		mic_bus_state_e bus_st;
		logic [31:0] rdata;
		logic vert_ovr;
		logic horiz_ovr;
		mic_code_s vert_sw;
		mic_code_s horiz_sw;
		mic_code_s vert_apply;
		mic_code_s horiz_apply;
		logic tx_dis;
		logic [2:0] rx_tap;
	} mic_regs_s;

	// whole state of the receive tap chain
	typedef struct packed {
		logic [6:0] stage;
		logic out;
	} mic_chain_s;

endpackage

// File: src/mic_rx_tap_chain.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// eight-tap delay chain for the read-capture clock
// ----------------------------------------------------------------------------
module mic_rx_tap_chain (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// source and tap choice
	input wire logic i_src,
	input wire logic [mic_pkg::MIC_TAP_W-1:0] i_tap_sel,
	// delayed copy
	output logic o_tapped
);
	import mic_pkg::*;

	mic_chain_s s_q;
	mic_chain_s s_d;
	logic [MIC_TAP_COUNT-1:0] tap;

	// tap zero is the undelayed source, each later tap adds one stage
	assign tap[0] = i_src;
	generate
		for (genvar k = 1; k < MIC_TAP_COUNT; k++) begin : g_tap
			assign tap[k] = s_q.stage[k-1];
		end
	endgenerate

	// shift the chain and pick the selected tap
	always_comb begin
		s_d = s_q;
		s_d.stage = {s_q.stage[5:0], i_src};
		s_d.out = tap[i_tap_sel];
	end

	// state register
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_tapped = s_q.out;

	// tap zero passes the source after the output stage only, the reset edge loads zero
	tap_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!$past(i_rst) && $past(i_tap_sel) == 3'h0 |-> o_tapped == $past(i_src))
		else $error("tap zero does not follow the source");

	// the last tap lags the source by eight cycles
	tap_last_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_tap_sel == 3'h7) [*8] ##1 (i_tap_sel == 3'h7) |-> o_tapped == $past(i_src, 8))
		else $error("last tap delay is wrong");

endmodule // mic_rx_tap_chain

// File: src/mic_dll_comp_regs.sv
`timescale 1ns/1ps


// ----------------------------------------------------------------------------
// compensation override and memory clock dll control registers
// ----------------------------------------------------------------------------
module mic_dll_comp_regs (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// avalon-mm slave
	input wire logic [mic_pkg::MIC_ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [mic_pkg::MIC_DATA_W-1:0] i_avs_writedata,
	input wire logic [mic_pkg::MIC_BE_W-1:0] i_avs_byteenable,
	output logic [mic_pkg::MIC_DATA_W-1:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// live codes from the compensation logic
	input wire mic_pkg::mic_code_s i_vert_live,
	input wire mic_pkg::mic_code_s i_horiz_live,
	// codes driven to the buffers and compensation run enables
	output mic_pkg::mic_code_s o_vert_code,
	output mic_pkg::mic_code_s o_horiz_code,
	output logic o_vert_comp_run,
	output logic o_horiz_comp_run,
	// delay loop controls
	output logic o_tx_delay_loop_en,
	output logic o_tx_delay_loop_bypass,
	output logic o_rx_delay_loop_bypass,
	// memory clock in, delayed capture clock out
	input wire logic i_mem_clk_smp,
	output logic o_rx_cap_clk
);
	import mic_pkg::*;

	// ------------------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------------------

	// true when the word address matches a register offset
	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
		reg_hit = (addr[7:2] == ofs[7:2]);
	endfunction

	// ------------------------------------------------------------------------
	// state and request decode
	// ------------------------------------------------------------------------

	mic_regs_s s_q;
	mic_regs_s s_d;
	logic req;
	logic commit_wr;
	logic take_rd;
	logic hit_comp;
	logic hit_dll;
	logic hit_rxtap;
	logic new_vovr;
	logic new_hovr;
	mic_code_s vert_view;
	mic_code_s horiz_view;
	logic [31:0] rd_word;

	// request seen and the two moments that matter
	assign req = i_avs_read | i_avs_write;
	assign commit_wr = i_avs_write & (s_q.bus_st == MIC_BUS_ACK);
	assign take_rd = i_avs_read & (s_q.bus_st == MIC_BUS_IDLE);

	// register select
	assign hit_comp = reg_hit(i_avs_address, MIC_COMP_OFS);
	assign hit_dll = reg_hit(i_avs_address, MIC_DLL_OFS);
	assign hit_rxtap = reg_hit(i_avs_address, MIC_RXTAP_OFS);

	// override bits as they stand after a write in this cycle
	assign new_vovr = (commit_wr & hit_comp & i_avs_byteenable[3]) ?
		i_avs_writedata[MIC_VERT_OVR_BIT] : s_q.vert_ovr;
	assign new_hovr = (commit_wr & hit_comp & i_avs_byteenable[1]) ?
		i_avs_writedata[MIC_HORIZ_OVR_BIT] : s_q.horiz_ovr;

	// code seen by software: live outside override, stored under it
	assign vert_view = s_q.vert_ovr ? s_q.vert_sw : i_vert_live;
	assign horiz_view = s_q.horiz_ovr ? s_q.horiz_sw : i_horiz_live;

	// ------------------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------------------

	// assemble the addressed word, reserved bits stay zero
	always_comb begin
		rd_word = 32'h0000_0000;
		if (hit_comp) begin
			rd_word[MIC_VERT_OVR_BIT] = s_q.vert_ovr;
			rd_word[MIC_VERT_P_LSB +: MIC_CODE_W] = vert_view.pchan;
			rd_word[MIC_VERT_N_LSB +: MIC_CODE_W] = vert_view.nchan;
			rd_word[MIC_HORIZ_OVR_BIT] = s_q.horiz_ovr;
			rd_word[MIC_HORIZ_P_LSB +: MIC_CODE_W] = horiz_view.pchan;
			rd_word[MIC_HORIZ_N_LSB +: MIC_CODE_W] = horiz_view.nchan;
		end else if (hit_dll) begin
			rd_word[MIC_TX_DIS_BIT] = s_q.tx_dis;
		end else if (hit_rxtap) begin
			rd_word[MIC_RX_TAP_LSB +: MIC_TAP_W] = s_q.rx_tap;
		end
	end

	// ------------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------------

	// bus sequencing, register writes and code steering
	always_comb begin
		s_d = s_q;

		// two-cycle handshake: take the request, then release waitrequest
		case (s_q.bus_st)
			MIC_BUS_IDLE: begin
				if (req) begin
					s_d.bus_st = MIC_BUS_ACK;
				end
			end
			MIC_BUS_ACK: begin
				s_d.bus_st = MIC_BUS_IDLE;
			end
			default: begin
				s_d.bus_st = MIC_BUS_IDLE;
			end
		endcase

		// read data is loaded early so it stands when waitrequest drops
		if (take_rd) begin
			s_d.rdata = rd_word & (hit_comp ? MIC_COMP_MASK : 32'hFFFF_FFFF);
		end

		// outside override the stored codes track compensation
		if (!s_q.vert_ovr) begin
			s_d.vert_sw = i_vert_live;
		end
		if (!s_q.horiz_ovr) begin
			s_d.horiz_sw = i_horiz_live;
		end

		// compensation register write, reserved bits are dropped
		if (commit_wr && hit_comp) begin
			s_d.vert_ovr = new_vovr;
			s_d.horiz_ovr = new_hovr;
			if (new_vovr && i_avs_byteenable[2]) begin
				s_d.vert_sw.pchan = i_avs_writedata[MIC_VERT_P_LSB +: MIC_CODE_W];
				s_d.vert_sw.nchan = i_avs_writedata[MIC_VERT_N_LSB +: MIC_CODE_W];
			end
			if (new_hovr && i_avs_byteenable[0]) begin
				s_d.horiz_sw.pchan = i_avs_writedata[MIC_HORIZ_P_LSB +: MIC_CODE_W];
				s_d.horiz_sw.nchan = i_avs_writedata[MIC_HORIZ_N_LSB +: MIC_CODE_W];
			end
		end

		// dll register write, only bit 15 is kept
		if (commit_wr && hit_dll && i_avs_byteenable[1]) begin
			s_d.tx_dis = i_avs_writedata[MIC_TX_DIS_BIT];
		end

		// receive tap register write
		if (commit_wr && hit_rxtap && i_avs_byteenable[0]) begin
			s_d.rx_tap = i_avs_writedata[MIC_RX_TAP_LSB +: MIC_TAP_W];
		end

		// codes driven to the buffers
		s_d.vert_apply = s_d.vert_ovr ? s_d.vert_sw : i_vert_live;
		s_d.horiz_apply = s_d.horiz_ovr ? s_d.horiz_sw : i_horiz_live;
	end

	// ------------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------------

	// reset to override off, transmit dll on, tap zero
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_q.bus_st <= MIC_BUS_IDLE;
			s_q.rdata <= MIC_RDATA_RST;
			s_q.vert_ovr <= MIC_OVR_RST;
			s_q.horiz_ovr <= MIC_OVR_RST;
			s_q.vert_sw <= {MIC_CODE_RST, MIC_CODE_RST};
			s_q.horiz_sw <= {MIC_CODE_RST, MIC_CODE_RST};
			s_q.vert_apply <= {MIC_CODE_RST, MIC_CODE_RST};
			s_q.horiz_apply <= {MIC_CODE_RST, MIC_CODE_RST};
			s_q.tx_dis <= MIC_TX_DIS_RST;
			s_q.rx_tap <= MIC_RX_TAP_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------------------
	// receive delay chain
	// ------------------------------------------------------------------------

	// capture clock is the memory clock through the selected tap
	mic_rx_tap_chain u_rx_chain (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_src(i_mem_clk_smp),
		.i_tap_sel(s_q.rx_tap),
		.o_tapped(o_rx_cap_clk)
	);

	// ------------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------------

	// bus answers
	assign o_avs_waitrequest = req & (s_q.bus_st != MIC_BUS_ACK);
	assign o_avs_readdata = s_q.rdata;

	// compensation steering
	assign o_vert_code = s_q.vert_apply;
	assign o_horiz_code = s_q.horiz_apply;
	assign o_vert_comp_run = ~s_q.vert_ovr;
	assign o_horiz_comp_run = ~s_q.horiz_ovr;

	// dll steering, receive loop never enabled
	assign o_tx_delay_loop_en = ~s_q.tx_dis;
	assign o_tx_delay_loop_bypass = s_q.tx_dis;
	assign o_rx_delay_loop_bypass = 1'b1;

	// ------------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------------

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	// helper: set once software has written the dll register
	logic tx_touched_q;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			tx_touched_q <= 1'b0;
		end else if (commit_wr && hit_dll) begin
			tx_touched_q <= 1'b1;
		end
	end

	// a request is held off one cycle and then answered
	bus_answer_a: assert property (
		req && s_q.bus_st == MIC_BUS_IDLE |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
		else $error("request not answered after one wait cycle");

	// writing the vertical override switches compensation off or on
	vert_run_a: assert property (
		commit_wr && hit_comp && i_avs_byteenable[3]
		|=> o_vert_comp_run == !$past(i_avs_writedata[31]))
		else $error("vertical run enable does not follow override");

	// vertical p code reads live compensation outside override
	vert_p_live_a: assert property (
		take_rd && hit_comp && !s_q.vert_ovr
		|=> o_avs_readdata[22:20] == $past(i_vert_live.pchan))
		else $error("vertical p code readback not live");

	// vertical n code reads live compensation outside override
	vert_n_live_a: assert property (
		take_rd && hit_comp && !s_q.vert_ovr
		|=> o_avs_readdata[18:16] == $past(i_vert_live.nchan))
		else $error("vertical n code readback not live");

	// an override write with codes drives those codes to the buffers
	vert_ovr_apply_a: assert property (
		commit_wr && hit_comp && i_avs_byteenable[3] && i_avs_byteenable[2]
		&& i_avs_writedata[31]
		|=> o_vert_code.pchan == $past(i_avs_writedata[22:20])
		&& o_vert_code.nchan == $past(i_avs_writedata[18:16]))
		else $error("vertical override codes not applied");

	// under override the horizontal codes hold while no write lands
	horiz_ovr_hold_a: assert property (
		s_q.horiz_ovr && !commit_wr ##1 s_q.horiz_ovr && !commit_wr
		|-> $stable(o_horiz_code))
		else $error("horizontal override codes drifted");

	// writing the horizontal override switches compensation off or on
	horiz_run_a: assert property (
		commit_wr && hit_comp && i_avs_byteenable[1]
		|=> o_horiz_comp_run == !$past(i_avs_writedata[15]))
		else $error("horizontal run enable does not follow override");

	// horizontal p code follows compensation outside override
	horiz_p_live_a: assert property (
		!s_q.horiz_ovr && !commit_wr
		|=> o_horiz_code.pchan == $past(i_horiz_live.pchan))
		else $error("horizontal p code not live");

	// horizontal n code reads live compensation outside override
	horiz_n_live_a: assert property (
		take_rd && hit_comp && !s_q.horiz_ovr
		|=> o_avs_readdata[2:0] == $past(i_horiz_live.nchan))
		else $error("horizontal n code readback not live");

	// the transmit dll bypass follows bit 15 and is the inverse of enable
	tx_dll_ctl_a: assert property (
		commit_wr && hit_dll && i_avs_byteenable[1]
		|=> o_tx_delay_loop_bypass == $past(i_avs_writedata[15])
		&& o_tx_delay_loop_en != o_tx_delay_loop_bypass)
		else $error("transmit dll control wrong");

	// transmit dll stays on from reset until software touches it
	tx_dll_reset_a: assert property (
		!tx_touched_q |-> o_tx_delay_loop_en && !o_tx_delay_loop_bypass)
		else $error("transmit dll not enabled after reset");

	// receive dll bypass never drops
	rx_bypass_a: assert property (
		o_rx_delay_loop_bypass [*2])
		else $error("receive dll left bypass");

	// tap setting written by software reaches the chain
	rx_tap_wr_a: assert property (
		commit_wr && hit_rxtap && i_avs_byteenable[0]
		|=> s_q.rx_tap == $past(i_avs_writedata[2:0]))
		else $error("receive tap setting not stored");

	// bits reserved in all three registers read as zero in any read word
	rsvd_zero_a: assert property (
		take_rd |=> (o_avs_readdata & ~(MIC_COMP_MASK | MIC_DLL_MASK | MIC_RXTAP_MASK))
		== 32'h0000_0000)
		else $error("reserved bits read nonzero");

	// writes to unmapped words leave every control unchanged
	unmapped_wr_a: assert property (
		commit_wr && !hit_comp && !hit_dll && !hit_rxtap
		|=> $stable(s_q.vert_ovr) && $stable(s_q.horiz_ovr) && $stable(s_q.tx_dis)
		&& $stable(s_q.rx_tap))
		else $error("unmapped write changed a control");

endmodule // mic_dll_comp_regs

// File: dv/tb.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// register block testbench
// ----------------------------------------------------------------------------
module tb;
	import mic_pkg::*;

	logic i_clk;
	logic i_rst;
	logic [MIC_ADDR_W-1:0] i_avs_address;
	logic i_avs_read;
	logic i_avs_write;
	logic [MIC_DATA_W-1:0] i_avs_writedata;
	logic [MIC_BE_W-1:0] i_avs_byteenable;
	logic [MIC_DATA_W-1:0] o_avs_readdata;
	logic o_avs_waitrequest;
	mic_code_s i_vert_live;
	mic_code_s i_horiz_live;
	mic_code_s o_vert_code;
	mic_code_s o_horiz_code;
	logic o_vert_comp_run;
	logic o_horiz_comp_run;
	logic o_tx_delay_loop_en;
	logic o_tx_delay_loop_bypass;
	logic o_rx_delay_loop_bypass;
	logic i_mem_clk_smp = 1'b0;
	logic o_rx_cap_clk;
	int n_fail = 0;
	int check_count = 0;
	int cyc = 0;
	logic [15:0] hist = 16'h0000;

	mic_dll_comp_regs DUT (
		.i_clk(i_clk), .i_rst(i_rst),
		.i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
		.i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
		.i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest),
		.i_vert_live(i_vert_live), .i_horiz_live(i_horiz_live),
		.o_vert_code(o_vert_code), .o_horiz_code(o_horiz_code),
		.o_vert_comp_run(o_vert_comp_run), .o_horiz_comp_run(o_horiz_comp_run),
		.o_tx_delay_loop_en(o_tx_delay_loop_en),
		.o_tx_delay_loop_bypass(o_tx_delay_loop_bypass),
		.o_rx_delay_loop_bypass(o_rx_delay_loop_bypass),
		.i_mem_clk_smp(i_mem_clk_smp), .o_rx_cap_clk(o_rx_cap_clk)
	);

	// ------------------------------------------------------------------------
	// clock, source pattern for the tap chain, history and hang guard
	// ------------------------------------------------------------------------
	initial i_clk = 1'b0;
	always #2 i_clk = ~i_clk;

	// irregular source so that each delay gives a different sequence
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		i_mem_clk_smp <= cyc[3] ^ cyc[1] ^ (cyc[0] & cyc[2]);
		hist <= {hist[14:0], i_mem_clk_smp};
		if (cyc == 4000) begin
			n_fail++;
			print_verdict();
		end
	end

	// ------------------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------------------
	task automatic print_verdict();
		$display("Counts: %0d mismatches in %0d checks", n_fail, check_count);
		if (n_fail == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// one avalon access, held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] data,
			input logic [3:0] be, output logic [31:0] rd);
		@(posedge i_clk);
		i_avs_read <= !wr;
		i_avs_write <= wr;
		i_avs_address <= addr;
		i_avs_writedata <= data;
		i_avs_byteenable <= be;
		// wait for the rising edge that sees waitrequest low, take read data there
		@(posedge i_clk iff !o_avs_waitrequest);
		rd = o_avs_readdata;
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
	endtask

	task automatic wr_reg(input logic [7:0] addr, input logic [31:0] data, input logic [3:0] be);
		logic [31:0] rd;
		bus(1'b1, addr, data, be, rd);
	endtask

	task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input string what);
		logic [31:0] rd;
		bus(1'b0, addr, 32'h0000_0000, 4'hF, rd);
		chk(rd, exp, what);
	endtask

	// let register updates reach the outputs before looking
	task automatic settle();
		@(posedge i_clk);
		@(negedge i_clk);
	endtask

	function automatic logic [31:0] comp_word(input logic vo, input mic_code_s v,
			input logic ho, input mic_code_s h);
		return {vo, 8'h00, v.pchan, 1'b0, v.nchan, ho, 8'h00, h.pchan, 1'b0, h.nchan};
	endfunction

	// run flags: vert run, horiz run, tx enable, tx bypass, rx bypass
	function automatic logic [31:0] flags();
		return {27'h0, o_vert_comp_run, o_horiz_comp_run, o_tx_delay_loop_en,
			o_tx_delay_loop_bypass, o_rx_delay_loop_bypass};
	endfunction

	function automatic logic [31:0] codes();
		return {20'h0, o_vert_code, o_horiz_code};
	endfunction

	task automatic set_live(input mic_code_s v, input mic_code_s h);
		@(posedge i_clk);
		i_vert_live <= v;
		i_horiz_live <= h;
		settle();
	endtask

	// ------------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------------
	task automatic t_reset();
		chk(flags(), 32'h0000_001D, "flags after reset");
		chk(codes(), {20'h0, 6'h2C, 6'h13}, "live codes after reset");
		rd_chk(MIC_COMP_OFS, comp_word(1'b0, 6'h2C, 1'b0, 6'h13), "comp read");
		rd_chk(MIC_DLL_OFS, 32'h0000_0000, "dll read");
		rd_chk(MIC_RXTAP_OFS, 32'h0000_0000, "tap read");
	endtask

	task automatic t_track();
		mic_code_s v;
		mic_code_s h;
		for (int i = 0; i < 4; i++) begin
			v = 6'(6'h07 * (i + 1) + 6'h20);
			h = 6'(6'h3F - 6'h0B * i);
			set_live(v, h);
			chk(codes(), {20'h0, v, h}, "tracked codes");
			rd_chk(MIC_COMP_OFS, comp_word(1'b0, v, 1'b0, h), "tracked read");
		end
		// code bits written without override are ignored
		wr_reg(MIC_COMP_OFS, 32'h0055_0055, 4'hF);
		settle();
		rd_chk(MIC_COMP_OFS, comp_word(1'b0, v, 1'b0, h), "ro code write");
	endtask

	task automatic t_overrides();
		// vertical override with codes; horizontal codes ignored since it stays off
		wr_reg(MIC_COMP_OFS, 32'h8052_0077, 4'hF);
		settle();
		chk(flags(), 32'h0000_000D, "vert stopped");
		set_live(6'h09, 6'h24);
		chk(codes(), {20'h0, 6'h2A, 6'h24}, "vert forced, horiz live");
		rd_chk(MIC_COMP_OFS, comp_word(1'b1, 6'h2A, 1'b0, 6'h24), "vert ovr read");
		// horizontal override through its own lanes only
		wr_reg(MIC_COMP_OFS, 32'h0000_8036, 4'h3);
		settle();
		chk(flags(), 32'h0000_0005, "both stopped");
		set_live(6'h12, 6'h01);
		chk(codes(), {20'h0, 6'h2A, 6'h1E}, "both forced");
		rd_chk(MIC_COMP_OFS, comp_word(1'b1, 6'h2A, 1'b1, 6'h1E), "both ovr read");
		// reserved bits stay zero
		wr_reg(MIC_COMP_OFS, 32'hFFFF_FFFF, 4'hF);
		rd_chk(MIC_COMP_OFS, MIC_COMP_MASK, "comp reserved");
		// release both, compensation resumes on live codes
		wr_reg(MIC_COMP_OFS, 32'h0000_0000, 4'hF);
		settle();
		chk(flags(), 32'h0000_001D, "both running");
		chk(codes(), {20'h0, 6'h12, 6'h01}, "live again");
	endtask

	task automatic t_dll();
		wr_reg(MIC_DLL_OFS, 32'hFFFF_FFFF, 4'hF);
		settle();
		chk(flags(), 32'h0000_001B, "tx loop off");
		rd_chk(MIC_DLL_OFS, 32'h0000_8000, "dll reserved");
		wr_reg(MIC_DLL_OFS, 32'h0000_0000, 4'hF);
		settle();
		chk(flags(), 32'h0000_001D, "tx loop on");
		wr_reg(8'h40, 32'hFFFF_FFFF, 4'hF);
		rd_chk(8'h40, 32'h0000_0000, "unmapped");
		rd_chk(MIC_COMP_OFS, comp_word(1'b0, 6'h12, 1'b0, 6'h01), "unmapped no effect");
	endtask

	task automatic t_taps();
		for (int k = 0; k < MIC_TAP_COUNT; k++) begin
			wr_reg(MIC_RXTAP_OFS, 32'(k), 4'hF);
			rd_chk(MIC_RXTAP_OFS, 32'(k), "tap select");
			repeat (3) @(posedge i_clk);
			for (int n = 0; n < 12; n++) begin
				@(negedge i_clk);
				chk({31'h0, o_rx_cap_clk}, {31'h0, hist[k]}, "tap delay");
			end
		end
		chk(flags(), 32'h0000_001D, "rx loop bypassed");
	endtask

	// ------------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------------
	initial begin
		i_rst = 1'b1;
		i_avs_address = 8'h00;
		i_avs_read = 1'b0;
		i_avs_write = 1'b0;
		i_avs_writedata = 32'h0000_0000;
		i_avs_byteenable = 4'h0;
		i_vert_live = 6'h2C;
		i_horiz_live = 6'h13;
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		settle();
		t_reset();
		t_track();
		t_overrides();
		t_dll();
		t_taps();
		print_verdict();
	end

endmodule // tb
